// *** cldp_pkg.sv ***
// shared constants and types for the decel / loop / power config bank
`default_nettype none
package cldp_pkg;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_DECEL   = 8'h8C;
	localparam logic [7:0] IDX_LOOP    = 8'h8E;
	localparam logic [7:0] IDX_POWER   = 8'h90;
	localparam logic [7:0] IDX_STATUS  = 8'h92;
	localparam logic [9:0] ADDR_DECEL  = {IDX_DECEL, 2'b00};
	localparam logic [9:0] ADDR_LOOP   = {IDX_LOOP, 2'b00};
	localparam logic [9:0] ADDR_POWER  = {IDX_POWER, 2'b00};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam int N_CFG = 3;
	// field positions, decel word
	localparam int PARITY_BIT  = 31;
	localparam int DC_BLANK    = 19;
	localparam int DC_WIN_LSB  = 16;
	localparam int DC_THR_LSB  = 13;
	localparam int DC_LOW_LSB  = 9;
	localparam int DC_RAMP     = 8;
	localparam int DC_EN       = 7;
	localparam int DC_UPP_LSB  = 3;
	localparam int DC_EXIT_LSB = 0;
	// field positions, loop word
	localparam int LP_KP_LSB   = 20;
	localparam int LP_KI_LSB   = 8;
	localparam int LP_MAX_LSB  = 5;
	localparam int LP_MIN_LSB  = 2;
	localparam int LP_MODE_LSB = 0;
	// field positions, power word
	localparam int PW_SPD_LSB  = 15;
	localparam int PW_DT       = 14;
	localparam int PW_PWR_LSB  = 4;
	localparam int PW_HYS_LSB  = 2;
	localparam int PW_MODE_LSB = 0;
	// scale of a current code, millivolts per step
	localparam logic [10:0] MV_PER_CODE = 11'h064;
	// status bit positions
	localparam int ST_LOW_RSV  = 0;
	localparam int ST_UPP_RSV  = 1;
	localparam int ST_LOOP_RSV = 2;
	localparam int ST_PWR_RSV  = 3;

	typedef enum logic [1:0] {LOOP_OFF, LOOP_SPEED, LOOP_POWER} cldp_loop_e;
	typedef enum logic [1:0] {PWR_OFF, PWR_CLOSED, PWR_LIMIT} cldp_pwr_e;

	// decoded deceleration settings, percentages in tenths
	typedef struct packed {
		logic        blank_en;
		logic [7:0]  duty_window_pm;
		logic [9:0]  duty_threshold_pm;
		logic [10:0] lower_limit_mv;
		logic        ramp_en;
		logic        enable;
		logic [10:0] upper_limit_mv;
		logic [5:0]  exit_delta_pm;
	} cldp_decel_s;

	// decoded speed / power loop settings
	typedef struct packed {
		logic [9:0]  prop_gain;
		logic [11:0] integ_gain;
		logic [9:0]  out_upper_pm;
		logic [7:0]  out_lower_pm;
		cldp_loop_e  mode;
	} cldp_loop_s;

	// decoded input power regulation settings
	typedef struct packed {
		logic [15:0] max_speed;
		logic        dt_comp_en;
		logic [9:0]  max_power;
		logic [6:0]  hyst_pm;
		cldp_pwr_e   mode;
	} cldp_power_s;
endpackage : cldp_pkg
`default_nettype wire

// *** cldp_regs.sv ***
// apb register bank for fast decel, speed/power loop and power regulation
//
// Functional notes
// - blanking enable bit during fast deceleration
// - duty window codes map 0 to 25 percent
// - duty threshold codes map 100 to 65 percent
// - lower current limit 0.1 V/code, 0 reserved
// - dynamic current limit reduction enable bit
// - fast deceleration enable bit
// - upper current limit 0.1 V/code, 0 reserved
// - exit speed delta codes 0.5 to 5 percent
// - proportional gain is field over 10000
// - integral gain is field over 1000000
// - loop upper saturation 100 to 65 percent
// - loop lower saturation 0 to 25 percent
// - loop mode off, speed, power, reserved
// - maximum speed is field over 16 Hz
// - dead-time compensation enable bit
// - maximum power is field over 4 W
// - power hysteresis 5 to 12.5 percent
// - power mode off, closed loop, limit, reserved
`default_nettype none
module cldp_regs
	import cldp_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	output cldp_pkg::cldp_decel_s   decel_cfg,
	output cldp_pkg::cldp_loop_s    loop_cfg,
	output cldp_pkg::cldp_power_s   power_cfg,
	output logic      [3:0]         code_fault
);
	import cldp_pkg::*;

	////////////////////////////////////////////////////////////////////
	// state of the whole bank in one record
	typedef struct packed {
		logic [N_CFG-1:0][31:0] word;      // stored config words
		logic [31:0]            rdata;     // read data for access phase
		logic                   ready;     // answer strobe
		logic                   err;       // refused access answer
		cldp_decel_s            decel;     // decoded decel settings
		cldp_loop_s             loop;      // decoded loop settings
		cldp_power_s            power;     // decoded power settings
		logic [3:0]             fault;     // reserved code seen
	} cldp_state_s;

	cldp_state_s st_q;                     // registered state
	cldp_state_s st_d;                     // next state

	////////////////////////////////////////////////////////////////////
	// decoders shared by more than one field, plus the address to slot decode

	// low duty / saturation table in tenths of a percent
	function automatic logic [7:0] low_pct(input logic [2:0] code);
		case (code)
			3'h0:    low_pct = 8'h00;
			3'h1:    low_pct = 8'h19;
			3'h2:    low_pct = 8'h32;
			3'h3:    low_pct = 8'h4B;
			3'h4:    low_pct = 8'h64;
			3'h5:    low_pct = 8'h96;
			3'h6:    low_pct = 8'hC8;
			default: low_pct = 8'hFA;
		endcase
	endfunction : low_pct

	// high duty / saturation table, 100 % less 5 % per step
	function automatic logic [9:0] high_pct(input logic [2:0] code);
		high_pct = 10'h3E8 - ({7'h00, code} * 10'h032);
	endfunction : high_pct

	// current code to millivolts; code 0 is reserved and reads as 0
	function automatic logic [10:0] code_mv(input logic [3:0] code);
		code_mv = {7'h00, code} * MV_PER_CODE;
	endfunction : code_mv

	// address to config slot, N_CFG when not a config word
	function automatic logic [1:0] slot_of(input logic [11:0] a);
		case (a[11:2])
			{2'b00, IDX_DECEL}: slot_of = 2'd0;
			{2'b00, IDX_LOOP}:  slot_of = 2'd1;
			{2'b00, IDX_POWER}: slot_of = 2'd2;
			default:         slot_of = 2'd3;
		endcase
	endfunction : slot_of

	////////////////////////////////////////////////////////////////////
	// bus decode

	logic       setup_ph;                  // first cycle of a transfer
	logic       wr_acc;                    // write accepted this edge
	logic [1:0] slot;                      // addressed config word
	logic       is_status;                 // status word addressed
	logic       addr_ok;                   // any mapped word

	always_comb begin
		setup_ph  = psel && !penable;
		wr_acc    = psel && penable && st_q.ready && pwrite && !st_q.err;
		slot      = slot_of(paddr);
		is_status = (paddr[11:2] == {2'b00, IDX_STATUS}) && (paddr[1:0] == 2'b00);
		// unaligned byte addresses are refused like unmapped ones
		addr_ok   = ((slot != 2'd3) && (paddr[1:0] == 2'b00)) || is_status;
	end

	////////////////////////////////////////////////////////////////////
	// next state: bus answer, storage, then decode of stored words
	always_comb begin
		st_d = st_q;
		// ready is raised for exactly the first access cycle, no waits
		st_d.ready = setup_ph;
		st_d.err   = 1'b0;
		st_d.rdata = 32'h0000_0000;
		if (setup_ph) begin
			// writes to the read-only status word are refused too
			st_d.err = !addr_ok || (is_status && pwrite);
			if (!pwrite && addr_ok) begin
				if (is_status)
					st_d.rdata = {28'h000_0000, st_q.fault};
				else
					st_d.rdata = st_q.word[slot];
			end
		end
		// byte lanes land only in the accepted cycle; all bits stored
		if (wr_acc && (slot != 2'd3)) begin
			for (int b = 0; b < 4; b++) begin
				if (pstrb[b])
					st_d.word[slot][8*b +: 8] = pwdata[8*b +: 8];
			end
		end

		// deceleration word
		st_d.decel.blank_en          = st_q.word[0][DC_BLANK];
		st_d.decel.duty_window_pm    = low_pct(st_q.word[0][DC_WIN_LSB +: 3]);
		st_d.decel.duty_threshold_pm = high_pct(st_q.word[0][DC_THR_LSB +: 3]);
		st_d.decel.lower_limit_mv    = code_mv(st_q.word[0][DC_LOW_LSB +: 4]);
		st_d.decel.ramp_en           = st_q.word[0][DC_RAMP];
		st_d.decel.enable            = st_q.word[0][DC_EN];
		st_d.decel.upper_limit_mv    = code_mv(st_q.word[0][DC_UPP_LSB +: 4]);
		// exit delta: half-percent steps, then whole percents at the top
		case (st_q.word[0][DC_EXIT_LSB +: 3])
			3'h6:    st_d.decel.exit_delta_pm = 6'h28;
			3'h7:    st_d.decel.exit_delta_pm = 6'h32;
			default: st_d.decel.exit_delta_pm =
				6'({3'h0, st_q.word[0][DC_EXIT_LSB +: 3]} * 6'h05 + 6'h05);
		endcase

		// loop word; gains leave as raw fields, scale sits in the consumer
		st_d.loop.prop_gain    = st_q.word[1][LP_KP_LSB +: 10];
		st_d.loop.integ_gain   = st_q.word[1][LP_KI_LSB +: 12];
		st_d.loop.out_upper_pm = high_pct(st_q.word[1][LP_MAX_LSB +: 3]);
		st_d.loop.out_lower_pm = low_pct(st_q.word[1][LP_MIN_LSB +: 3]);
		// reserved mode falls back to off so a bad write stops the loop
		case (st_q.word[1][LP_MODE_LSB +: 2])
			2'h1:    st_d.loop.mode = LOOP_SPEED;
			2'h2:    st_d.loop.mode = LOOP_POWER;
			default: st_d.loop.mode = LOOP_OFF;
		endcase

		// power word; speed and power are raw fixed-point fields
		st_d.power.max_speed  = st_q.word[2][PW_SPD_LSB +: 16];
		st_d.power.dt_comp_en = st_q.word[2][PW_DT];
		st_d.power.max_power  = st_q.word[2][PW_PWR_LSB +: 10];
		st_d.power.hyst_pm    =
			7'({5'h00, st_q.word[2][PW_HYS_LSB +: 2]} * 7'h19 + 7'h32);
		case (st_q.word[2][PW_MODE_LSB +: 2])
			2'h1:    st_d.power.mode = PWR_CLOSED;
			2'h2:    st_d.power.mode = PWR_LIMIT;
			default: st_d.power.mode = PWR_OFF;
		endcase

		// reserved codes are flagged, not trapped; software owns them
		st_d.fault[ST_LOW_RSV]  = (st_q.word[0][DC_LOW_LSB +: 4] == 4'h0);
		st_d.fault[ST_UPP_RSV]  = (st_q.word[0][DC_UPP_LSB +: 4] == 4'h0);
		st_d.fault[ST_LOOP_RSV] = (st_q.word[1][LP_MODE_LSB +: 2] == 2'h3);
		st_d.fault[ST_PWR_RSV]  = (st_q.word[2][PW_MODE_LSB +: 2] == 2'h3);
	end

	////////////////////////////////////////////////////////////////////
	// one register stage for everything, synchronous reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= '0;
			for (int i = 0; i < N_CFG; i++)
				st_q.word[i] <= RESET_WORD;
			// decoded reset values of the all-zero words
			st_q.decel.duty_threshold_pm <= 10'h3E8;
			st_q.decel.exit_delta_pm     <= 6'h05;
			st_q.loop.out_upper_pm       <= 10'h3E8;
			st_q.power.hyst_pm           <= 7'h32;
			st_q.fault                   <= 4'h3;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign prdata     = st_q.rdata;
	assign pready     = st_q.ready;
	assign pslverr    = st_q.err;
	assign decel_cfg  = st_q.decel;
	assign loop_cfg   = st_q.loop;
	assign power_cfg  = st_q.power;
	assign code_fault = st_q.fault;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic wr_dec;                          // full-lane write to decel word
	logic wr_loop;                         // full-lane write to loop word
	logic wr_pwr;                          // full-lane write to power word
	always_comb begin
		wr_dec  = wr_acc && (slot == 2'd0) && (pstrb == 4'hF);
		wr_loop = wr_acc && (slot == 2'd1) && (pstrb == 4'hF);
		wr_pwr  = wr_acc && (slot == 2'd2) && (pstrb == 4'hF);
	end

	chk_parity_kept: assert property (
		wr_dec |=> st_q.word[0][PARITY_BIT] == $past(pwdata[PARITY_BIT]))
		else $error("parity bit not stored");
	chk_blank_bits: assert property (
		wr_dec |=> ##1 decel_cfg.blank_en == $past(pwdata[DC_BLANK], 2)
			&& decel_cfg.ramp_en == $past(pwdata[DC_RAMP], 2)
			&& decel_cfg.enable == $past(pwdata[DC_EN], 2))
		else $error("decel enable bits wrong");
	chk_window_top: assert property (
		wr_dec && pwdata[DC_WIN_LSB +: 3] == 3'h7 |=> ##1 decel_cfg.duty_window_pm == 8'hFA)
		else $error("duty window top code wrong");
	chk_thresh_low: assert property (
		wr_dec && pwdata[DC_THR_LSB +: 3] == 3'h7 |=> ##1 decel_cfg.duty_threshold_pm == 10'h28A)
		else $error("duty threshold code 7 wrong");
	chk_lower_rsv: assert property (
		wr_dec |=> ##1 code_fault[ST_LOW_RSV] == ($past(pwdata[DC_LOW_LSB +: 4], 2) == 4'h0))
		else $error("lower limit reserved flag wrong");
	chk_upper_mv: assert property (
		wr_dec && pwdata[DC_UPP_LSB +: 4] == 4'hB |=> ##1 decel_cfg.upper_limit_mv == 11'h44C)
		else $error("upper limit millivolts wrong");
	chk_exit_six: assert property (
		wr_dec && pwdata[DC_EXIT_LSB +: 3] == 3'h6 |=> ##1 decel_cfg.exit_delta_pm == 6'h28)
		else $error("exit delta code 6 wrong");
	chk_gain_fields: assert property (
		wr_loop |=> ##1 loop_cfg.prop_gain == $past(pwdata[LP_KP_LSB +: 10], 2)
			&& loop_cfg.integ_gain == $past(pwdata[LP_KI_LSB +: 12], 2))
		else $error("loop gains wrong");
	chk_loop_rsv: assert property (
		wr_loop && pwdata[LP_MODE_LSB +: 2] == 2'h3 |=> ##1 loop_cfg.mode == LOOP_OFF
			&& code_fault[ST_LOOP_RSV])
		else $error("reserved loop mode not off");
	chk_power_hyst: assert property (
		wr_pwr && pwdata[PW_HYS_LSB +: 2] == 2'h3 |=> ##1 power_cfg.hyst_pm == 7'h7D)
		else $error("hysteresis code 3 wrong");
	chk_power_mode: assert property (
		wr_pwr && pwdata[PW_MODE_LSB +: 2] == 2'h2 |=> ##1 power_cfg.mode == PWR_LIMIT)
		else $error("power limit mode wrong");
	chk_ready_once: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("ready not a single access cycle");

	////////////////////////////////////////////////////////////////////
	// further decodes, storage and bus answers
	// window code 5 is the first of the coarse steps
	chk_window_five: assert property (
		wr_dec && pwdata[DC_WIN_LSB +: 3] == 3'h5
		|=> ##1 decel_cfg.duty_window_pm == 8'h96)
		else $error("duty window code 5 wrong");
	// threshold code 0 means full duty
	chk_thresh_full: assert property (
		wr_dec && pwdata[DC_THR_LSB +: 3] == 3'h0
		|=> ##1 decel_cfg.duty_threshold_pm == 10'h3E8)
		else $error("duty threshold code 0 wrong");
	// lower limit code 14 gives 1.4 V
	chk_lower_mv: assert property (
		wr_dec && pwdata[DC_LOW_LSB +: 4] == 4'hE
		|=> ##1 decel_cfg.lower_limit_mv == 11'h578)
		else $error("lower limit millivolts wrong");
	// reserved upper code flagged two edges after the write
	chk_upper_rsv: assert property (
		wr_dec
		|=> ##1 code_fault[ST_UPP_RSV] == ($past(pwdata[DC_UPP_LSB +: 4], 2) == 4'h0))
		else $error("upper limit reserved flag wrong");
	// exit code 0 is the half-percent floor
	chk_exit_base: assert property (
		wr_dec && pwdata[DC_EXIT_LSB +: 3] == 3'h0
		|=> ##1 decel_cfg.exit_delta_pm == 6'h05)
		else $error("exit delta code 0 wrong");
	// upper saturation bottoms out at 65 %
	chk_loop_upper: assert property (
		wr_loop && pwdata[LP_MAX_LSB +: 3] == 3'h7
		|=> ##1 loop_cfg.out_upper_pm == 10'h28A)
		else $error("loop upper limit code 7 wrong");
	// lower saturation code 3 is 7.5 %
	chk_loop_lower: assert property (
		wr_loop && pwdata[LP_MIN_LSB +: 3] == 3'h3
		|=> ##1 loop_cfg.out_lower_pm == 8'h4B)
		else $error("loop lower limit code 3 wrong");
	// speed mode is a legal code, so no flag
	chk_loop_speed: assert property (
		wr_loop && pwdata[LP_MODE_LSB +: 2] == 2'h1
		|=> ##1 loop_cfg.mode == LOOP_SPEED && !code_fault[ST_LOOP_RSV])
		else $error("speed loop mode wrong");
	// raw fixed-point fields pass through untouched
	chk_power_fields: assert property (
		wr_pwr
		|=> ##1 power_cfg.max_speed == $past(pwdata[PW_SPD_LSB +: 16], 2)
			&& power_cfg.dt_comp_en == $past(pwdata[PW_DT], 2)
			&& power_cfg.max_power == $past(pwdata[PW_PWR_LSB +: 10], 2))
		else $error("power word fields wrong");
	// hysteresis code 0 is 5 %
	chk_hyst_base: assert property (
		wr_pwr && pwdata[PW_HYS_LSB +: 2] == 2'h0
		|=> ##1 power_cfg.hyst_pm == 7'h32)
		else $error("hysteresis code 0 wrong");
	// reserved power mode falls back to off and is flagged
	chk_power_rsv: assert property (
		wr_pwr && pwdata[PW_MODE_LSB +: 2] == 2'h3
		|=> ##1 power_cfg.mode == PWR_OFF && code_fault[ST_PWR_RSV])
		else $error("reserved power mode not off");
	// every bit of the loop word is kept, parity included
	chk_store_loop: assert property (
		wr_loop
		|=> st_q.word[1] == $past(pwdata))
		else $error("loop word not stored");
	// every bit of the power word is kept, parity included
	chk_store_power: assert property (
		wr_pwr
		|=> st_q.word[2] == $past(pwdata))
		else $error("power word not stored");
	// a refused access leaves all words alone
	chk_refused_keep: assert property (
		pready && pslverr
		|=> st_q.word == $past(st_q.word))
		else $error("refused access changed storage");
	// the status word cannot be written
	chk_status_ro: assert property (
		setup_ph && is_status && pwrite
		|=> pready && pslverr)
		else $error("status write not refused");
	// unmapped or unaligned places answer with an error
	chk_unmapped_err: assert property (
		setup_ph && !addr_ok
		|=> pready && pslverr)
		else $error("unmapped access not refused");
	// the error flag only ever travels with ready
	chk_err_with_ready: assert property (
		!pready
		|-> !pslverr)
		else $error("error without ready");
	// read data is zero outside the answer cycle
	chk_rdata_idle: assert property (
		!pready
		|-> prdata == 32'h0000_0000)
		else $error("read data not zero when idle");
	// ready only follows a setup cycle, never a stray access
	chk_ready_setup: assert property (
		pready
		|-> $past(psel) && !$past(penable))
		else $error("ready without a setup cycle");
	// all-zero words carry both reserved current codes
	chk_reset_fault: assert property (
		$fell(rst)
		|-> code_fault == 4'h3)
		else $error("reset fault flags wrong");
	// decoded reset values of the all-zero words, bus quiet
	chk_reset_decode: assert property (
		$fell(rst)
		|-> decel_cfg.duty_threshold_pm == 10'h3E8 && loop_cfg.mode == LOOP_OFF
			&& power_cfg.mode == PWR_OFF && !pready)
		else $error("reset decode wrong");
endmodule : cldp_regs
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the decel, loop and power configuration bank
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cldp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// expected duty window and exit delta per code, tenths of a percent
	typedef struct packed {
		logic [7:0] win;
		logic [5:0] ext;
	} cldp_row_s;
	cldp_row_s rows [8] = '{'{8'h00, 6'h05}, '{8'h19, 6'h0A}, '{8'h32, 6'h0F}, '{8'h4B, 6'h14},
		'{8'h64, 6'h19}, '{8'h96, 6'h1E}, '{8'hC8, 6'h28}, '{8'hFA, 6'h32}};
	localparam logic [11:0] A_DEC  = {2'b00, ADDR_DECEL};  // byte addresses
	localparam logic [11:0] A_LOOP = {2'b00, ADDR_LOOP};
	localparam logic [11:0] A_PWR  = {2'b00, ADDR_POWER};
	localparam logic [11:0] A_ST   = {2'b00, ADDR_STATUS};

	logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb, code_fault;
	cldp_decel_s decel_cfg;
	cldp_loop_s  loop_cfg;
	cldp_power_s power_cfg;
	int          error_cnt = 0;                                // mismatches seen
	int          n_tests   = 0;                                // comparisons made
	int          cyc       = 0;                                // timeout counter

	cldp_regs dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .decel_cfg(decel_cfg), .loop_cfg(loop_cfg),
		.power_cfg(power_cfg), .code_fault(code_fault));

	// 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// closing report, reached from the main sequence or the timeout
	task automatic results();
		$display("mismatches %0d, comparisons %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// case-equality compare, wide enough for any decoded struct
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; entered just after an edge, leaves just after one
	// hold keeps psel up so the next setup follows at once
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
		input logic [3:0] strb, input logic hold, output logic [31:0] rd, output logic err);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= addr;
		pwdata <= data;
		pstrb  <= strb;
		@(posedge ref_clk);
		penable <= 1'b1;
		// the slave decides when it answers; only the bench timeout ends the wait
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		penable <= 1'b0;
		if (!hold) begin
			psel <= 1'b0;
			@(posedge ref_clk);
		end
	endtask : apb

	task automatic wr32(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic e);
		logic [31:0] r;
		logic        x;
		apb(1'b1, a, d, s, 1'b0, r, x);
		check(64'(x), 64'(e));
		check(64'(pready), 64'h0);                                 // answer stands one cycle
	endtask : wr32

	task automatic rd32(input logic [11:0] a, input logic [31:0] d, input logic e);
		logic [31:0] r;
		logic        x;
		apb(1'b0, a, 32'h0000_0000, 4'h0, 1'b0, r, x);
		check(64'(r), 64'(d));
		check(64'(x), 64'(e));
	endtask : rd32

	// reset state of storage, decode and status
	task automatic chk_reset();
		cldp_decel_s d;
		cldp_loop_s  l;
		cldp_power_s p;
		d = '0;
		d.duty_threshold_pm = 10'h3E8;
		d.exit_delta_pm = 6'h05;
		l = '0;
		l.out_upper_pm = 10'h3E8;
		p = '0;
		p.hyst_pm = 7'h32;
		check(64'(decel_cfg), 64'(d));
		check(64'(loop_cfg), 64'(l));
		check(64'(power_cfg), 64'(p));
		rd32(A_DEC, 32'h0000_0000, 1'b0);
		rd32(A_LOOP, 32'h0000_0000, 1'b0);
		rd32(A_PWR, 32'h0000_0000, 1'b0);
		rd32(A_ST, 32'h0000_0003, 1'b0);
	endtask : chk_reset

	// hang guard, generous next to the few hundred cycles needed
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [2:0]  cc;
		logic [3:0]  lo, up;
		logic        m3, erv;
		logic [31:0] dw, lw, pw, rdv;
		cldp_decel_s ed;
		cldp_loop_s  el;
		cldp_power_s ep;
		rst <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0000_0000;
		pstrb <= 4'h0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk_reset();
		// every code of every 2- and 3-bit coded field, eight of the 16 codes of each current limit, reserved codes included
		for (int c = 0; c < 8; c++) begin
			cc = 3'(c);
			lo = {cc, 1'b0};                                         // code 0 is reserved
			up = 4'(11 + 3 * c);                                     // 11 first, 0 at code 7
			m3 = (cc[1:0] == 2'b11);
			dw = {cc[0], 11'h000, cc[0], cc, cc, lo, cc[1], cc[2], up, cc};
			lw = {cc[0], 1'b0, cc, 7'h55, cc, 9'h0AA, cc, cc, cc[1:0]};
			pw = {cc[0], cc, 13'h0F0F, cc[0], cc, 7'h5A, cc[1:0], cc[1:0]};
			wr32(A_DEC, dw, 4'hF, 1'b0);
			wr32(A_LOOP, lw, 4'hF, 1'b0);
			wr32(A_PWR, pw, 4'hF, 1'b0);
			rd32(A_DEC, dw, 1'b0);
			rd32(A_LOOP, lw, 1'b0);
			rd32(A_PWR, pw, 1'b0);
			rd32(A_ST, {28'h0, m3, m3, up == 4'h0, lo == 4'h0}, 1'b0);
			check(64'(code_fault), 64'({m3, m3, up == 4'h0, lo == 4'h0}));
			ed = '{blank_en: cc[0], duty_window_pm: rows[c].win,
				duty_threshold_pm: 10'(1000 - 50 * c), lower_limit_mv: 11'(100 * lo),
				ramp_en: cc[1], enable: cc[2], upper_limit_mv: 11'(100 * up),
				exit_delta_pm: rows[c].ext};
			el = '{prop_gain: {cc, 7'h55}, integ_gain: {cc, 9'h0AA},
				out_upper_pm: 10'(1000 - 50 * c), out_lower_pm: rows[c].win,
				mode: m3 ? LOOP_OFF : cldp_loop_e'(cc[1:0])};
			ep = '{max_speed: {cc, 13'h0F0F}, dt_comp_en: cc[0], max_power: {cc, 7'h5A},
				hyst_pm: 7'(50 + 25 * cc[1:0]), mode: m3 ? PWR_OFF : cldp_pwr_e'(cc[1:0])};
			check(64'(decel_cfg), 64'(ed));
			check(64'(loop_cfg), 64'(el));
			check(64'(power_cfg), 64'(ep));
		end
		// byte lanes: only lanes 0 and 2 take the write
		wr32(A_DEC, 32'h0000_0000, 4'hF, 1'b0);
		wr32(A_DEC, 32'hFFFF_FFFF, 4'h5, 1'b0);
		rd32(A_DEC, 32'h00FF_00FF, 1'b0);
		// back-to-back write then read, parity bit kept as written
		apb(1'b1, A_LOOP, 32'h8000_0001, 4'hF, 1'b1, rdv, erv);
		check(64'(erv), 64'h0);
		rd32(A_LOOP, 32'h8000_0001, 1'b0);
		check(64'(loop_cfg.mode), 64'(LOOP_SPEED));
		// refusals: unmapped, unaligned and read-only places store nothing
		rd32(12'h004, 32'h0000_0000, 1'b1);
		wr32(A_DEC + 12'h001, 32'hFFFF_FFFF, 4'hF, 1'b1);
		wr32(A_ST, 32'hFFFF_FFFF, 4'hF, 1'b1);
		rd32(A_DEC, 32'h00FF_00FF, 1'b0);
		// second reset in mid-run returns everything to zero words
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk_reset();
		results();
	end
endmodule : tb_top
`default_nettype wire
